// ==== rtl/pal_color_store.sv ====
`timescale 1ns/1ps
module pal_color_store #(
    parameter int ENTRIES = 256,
    parameter int OVERLAYS = 16
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    pal_store_if.store st
);
    import pal_pkg::*;

    pal_color_t ram_ff [ENTRIES];
    pal_color_t ovl_ff [OVERLAYS];

    // Overlay entry 0 is reserved and never written
    wire ovl_wr = st.wr_en && st.wr_ovl && (st.wr_idx[3:0] != 4'h0);
    wire ram_wr = st.wr_en && !st.wr_ovl;
    wire [3:0] host_ovl_idx = st.host_idx[3:0];

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < ENTRIES; i++) ram_ff[i] <= '0;
            for (int i = 0; i < OVERLAYS; i++) ovl_ff[i] <= '0;
        end else begin
            if (ram_wr) ram_ff[st.wr_idx] <= st.wr_data;
            if (ovl_wr) ovl_ff[st.wr_idx[3:0]] <= st.wr_data;
        end
    end

    assign st.host_data = st.host_ovl ? ovl_ff[host_ovl_idx]
                                      : ram_ff[st.host_idx];
    assign st.pix_data = (st.pix_ovl != 4'h0) ? ovl_ff[st.pix_ovl]
                                              : ram_ff[st.pix_idx];
endmodule

// ==== rtl/pal_host_port.sv ====
`timescale 1ns/1ps
`include "pal_regs.svh"
module pal_host_port (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [2:0] reg_select_i,
    input wire logic [7:0] host_bus_i,
    output logic [7:0] host_bus_o,
    output logic host_bus_oe_o,
    input wire logic width_sel_i,
    input wire logic [7:0] pixel_i,
    input wire logic [3:0] overlay_i,
    output pal_pkg::pal_color_t color_o,
    output pal_pkg::pal_byte_t palette_pointer_o,
    output pal_pkg::pal_mode_e access_mode_o
);
    import pal_pkg::*;

    pal_store_if st ();

    logic [13:0] pins_async;
    logic [13:0] pins_sync;
    logic rd_n_s;
    logic wr_n_s;
    logic [2:0] sel_s;
    pal_byte_t bus_s;
    logic wide_s;

    logic rd_n_d_ff;
    logic wr_n_d_ff;
    logic [2:0] rd_sel_ff;
    pal_byte_t pointer_ff;
    logic [1:0] count_ff;
    pal_mode_e mode_ff;
    pal_byte_t mask_ff;
    pal_byte_t red_ff;
    pal_byte_t green_ff;
    pal_byte_t bus_out_ff;
    logic bus_oe_ff;
    pal_color_t color_ff;
    logic wr_en_ff;
    logic wr_ovl_ff;
    pal_byte_t wr_idx_ff;
    pal_color_t wr_data_ff;
    pal_byte_t nxt_pointer;
    logic [1:0] nxt_count;
    pal_mode_e nxt_mode;
    pal_byte_t nxt_bus_out;
    pal_color_t nxt_color;
    logic drive_now;

    assign pins_async = {rd_n_i, wr_n_i, reg_select_i, host_bus_i,
                         width_sel_i};

    pal_sync #(
        .WIDTH(14),
        .RESET_VAL(14'h3001)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i(pins_async),
        .sync_o(pins_sync)
    );

    assign rd_n_s = pins_sync[13];
    assign wr_n_s = pins_sync[12];
    assign sel_s = pins_sync[11:9];
    assign bus_s = pins_sync[8:1];
    assign wide_s = pins_sync[0];

    // Strobe edges
    wire rd_fall = rd_n_d_ff && !rd_n_s;
    wire rd_rise = !rd_n_d_ff && rd_n_s;
    wire wr_rise = !wr_n_d_ff && wr_n_s;

    // Write decode at end of the write strobe
    wire wr_is_ptr = (sel_s == `PAL_SEL_PTR_RAM_WR) ||
                     (sel_s == `PAL_SEL_PTR_RAM_RD) ||
                     (sel_s == `PAL_SEL_PTR_OVL_WR) ||
                     (sel_s == `PAL_SEL_PTR_OVL_RD);
    wire wr_is_ram = sel_s == `PAL_SEL_RAM;
    wire wr_is_ovl = sel_s == `PAL_SEL_OVL;
    wire wr_is_mask = sel_s == `PAL_SEL_MASK;
    wire wr_is_color = wr_is_ram || wr_is_ovl;

    // Read decode uses the select caught at the read strobe fall
    wire rd_is_ptr = (rd_sel_ff == `PAL_SEL_PTR_RAM_WR) ||
                     (rd_sel_ff == `PAL_SEL_PTR_RAM_RD) ||
                     (rd_sel_ff == `PAL_SEL_PTR_OVL_WR) ||
                     (rd_sel_ff == `PAL_SEL_PTR_OVL_RD);
    wire rd_is_ram = rd_sel_ff == `PAL_SEL_RAM;
    wire rd_is_ovl = rd_sel_ff == `PAL_SEL_OVL;
    wire rd_is_mask = rd_sel_ff == `PAL_SEL_MASK;
    wire rd_is_color = rd_is_ram || rd_is_ovl;

    // Counter walks red, green, blue and back to red
    wire cnt_blue = count_ff == `PAL_CNT_BLUE;
    wire [1:0] cnt_step = cnt_blue ? `PAL_CNT_RED
                                   : count_ff + 2'h1;
    wire pal_byte_t ptr_step = pointer_ff + 8'h01;

    // Color byte in, per width
    wire pal_byte_t comp_in = wide_s ? bus_s
                                     : {2'h0, bus_s[5:0]};

    // Color byte out, per component and width
    wire pal_byte_t comp_sel =
        (count_ff == `PAL_CNT_RED) ? st.host_data[23:16] :
        (count_ff == `PAL_CNT_GREEN) ? st.host_data[15:8] :
        st.host_data[7:0];
    wire rsvd_ovl = rd_is_ovl && (pointer_ff[3:0] == 4'h0);
    wire pal_byte_t comp_out = rsvd_ovl ? 8'h00 :
                               wide_s ? comp_sel
                                      : {2'h0, comp_sel[5:0]};

    wire pal_byte_t rd_data = rd_is_ptr ? pointer_ff :
                              rd_is_mask ? mask_ff :
                              rd_is_color ? comp_out : 8'h00;

    wire pal_mode_e wr_mode =
        (sel_s == `PAL_SEL_PTR_RAM_WR) ? PAL_MODE_RAM_WR :
        (sel_s == `PAL_SEL_PTR_RAM_RD) ? PAL_MODE_RAM_RD :
        (sel_s == `PAL_SEL_PTR_OVL_WR) ? PAL_MODE_OVL_WR :
        PAL_MODE_OVL_RD;

    wire blue_wr = wr_rise && wr_is_color && cnt_blue;
    wire blue_rd = rd_rise && rd_is_color && cnt_blue;

    // Host and pixel lookups, host overlay index ignores pointer upper nibble
    assign st.host_ovl = rd_is_color ? rd_is_ovl : 1'b0;
    assign st.host_idx = rd_is_ovl ? {4'h0, pointer_ff[3:0]}
                                   : pointer_ff;
    assign st.pix_idx = pixel_i & mask_ff;
    assign st.pix_ovl = overlay_i;
    assign st.wr_en = wr_en_ff;
    assign st.wr_ovl = wr_ovl_ff;
    assign st.wr_idx = wr_idx_ff;
    assign st.wr_data = wr_data_ff;

    wire host_idle = rd_n_s && wr_n_s && rd_n_d_ff && wr_n_d_ff;

    pal_color_store #(
        .ENTRIES(256),
        .OVERLAYS(16)
    ) u_store (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .st(st)
    );

    // Next pointer, counter and access mode
    wire ptr_load = wr_rise && wr_is_ptr;
    wire cnt_adv = (wr_rise && wr_is_color) || (rd_rise && rd_is_color);
    wire ptr_adv = blue_wr || blue_rd;

    assign nxt_pointer = ptr_load ? bus_s :
                         ptr_adv ? ptr_step : pointer_ff;
    assign nxt_count = ptr_load ? `PAL_CNT_RED :
                       cnt_adv ? cnt_step : count_ff;
    assign nxt_mode = ptr_load ? wr_mode : mode_ff;

    // Component capture and mask load
    wire red_wr = wr_rise && wr_is_color && count_ff == `PAL_CNT_RED;
    wire green_wr = wr_rise && wr_is_color &&
                    count_ff == `PAL_CNT_GREEN;
    wire mask_wr = wr_rise && wr_is_mask;
    wire pal_byte_t store_idx = wr_is_ovl ? {4'h0, pointer_ff[3:0]}
                                          : pointer_ff;

    // Drive starts the cycle after the select is caught
    assign drive_now = !rd_n_s && !rd_fall;
    assign nxt_bus_out = drive_now ? rd_data : 8'h00;
    assign nxt_color = host_idle ? st.pix_data : color_ff;

    // Strobe history for edge detection
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_n_d_ff <= 1'b1;
            wr_n_d_ff <= 1'b1;
        end else begin
            rd_n_d_ff <= rd_n_s;
            wr_n_d_ff <= wr_n_s;
        end
    end

    // Select held from the read strobe fall to the next read
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_sel_ff <= `PAL_SEL_RSVD;
        end else if (rd_fall) begin
            rd_sel_ff <= sel_s;
        end
    end

    // Pointer, loaded by the host or stepped after blue
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pointer_ff <= `PAL_PTR_RESET;
        end else begin
            pointer_ff <= nxt_pointer;
        end
    end

    // Hidden counter, never on the host bus
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_ff <= `PAL_CNT_RED;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Mode changes only on a pointer write
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_ff <= PAL_MODE_RAM_WR;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Red and green held until the blue write
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            red_ff <= 8'h00;
        end else if (red_wr) begin
            red_ff <= comp_in;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            green_ff <= 8'h00;
        end else if (green_wr) begin
            green_ff <= comp_in;
        end
    end

    // Pixel read mask, written with no component step
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_ff <= `PAL_MASK_RESET;
        end else if (mask_wr) begin
            mask_ff <= bus_s;
        end
    end

    // One-cycle store write on blue
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_en_ff <= 1'b0;
        end else begin
            wr_en_ff <= blue_wr;
        end
    end

    // Store target and data registered with the strobe
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ovl_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
            wr_data_ff <= 24'h000000;
        end else if (blue_wr) begin
            wr_ovl_ff <= wr_is_ovl;
            wr_idx_ff <= store_idx;
            wr_data_ff <= {red_ff, green_ff, comp_in};
        end
    end

    // Bus driven from two cycles after the synced read strobe falls, and released the cycle after that strobe rises
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_oe_ff <= 1'b0;
        end else begin
            bus_oe_ff <= drive_now;
        end
    end

    // Data forced to zero whenever the bus is released
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_out_ff <= 8'h00;
        end else begin
            bus_out_ff <= nxt_bus_out;
        end
    end

    // Pixel color register refreshed only between host accesses
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            color_ff <= 24'h000000;
        end else begin
            color_ff <= nxt_color;
        end
    end

    assign host_bus_o = bus_out_ff;
    assign host_bus_oe_o = bus_oe_ff;
    assign color_o = color_ff;
    assign palette_pointer_o = pointer_ff;
    assign access_mode_o = mode_ff;
endmodule

// ==== rtl/pal_pkg.sv ====
package pal_pkg;
    typedef logic [7:0] pal_byte_t;
    typedef logic [23:0] pal_color_t;
    typedef enum logic [1:0] {
        PAL_MODE_RAM_WR,
        PAL_MODE_RAM_RD,
        PAL_MODE_OVL_WR,
        PAL_MODE_OVL_RD
    } pal_mode_e;
endpackage

// ==== rtl/pal_regs.svh ====
`ifndef PAL_REGS_SVH
`define PAL_REGS_SVH

`define PAL_SEL_PTR_RAM_WR 3'h0
`define PAL_SEL_RAM 3'h1
`define PAL_SEL_MASK 3'h2
`define PAL_SEL_PTR_RAM_RD 3'h3
`define PAL_SEL_PTR_OVL_WR 3'h4
`define PAL_SEL_OVL 3'h5
`define PAL_SEL_RSVD 3'h6
`define PAL_SEL_PTR_OVL_RD 3'h7

`define PAL_CNT_RED 2'h0
`define PAL_CNT_GREEN 2'h1
`define PAL_CNT_BLUE 2'h2

`define PAL_PTR_RESET 8'h00
`define PAL_MASK_RESET 8'hFF
`define PAL_SYNC_STAGES 2

`endif

// ==== rtl/pal_store_if.sv ====
`timescale 1ns/1ps
interface pal_store_if;
    import pal_pkg::*;
    logic wr_en;
    logic wr_ovl;
    pal_byte_t wr_idx;
    pal_color_t wr_data;
    logic host_ovl;
    pal_byte_t host_idx;
    pal_color_t host_data;
    pal_byte_t pix_idx;
    logic [3:0] pix_ovl;
    pal_color_t pix_data;
    modport ctrl (
        output wr_en, wr_ovl, wr_idx, wr_data, host_ovl, host_idx,
        output pix_idx, pix_ovl,
        input host_data, pix_data
    );
    modport store (
        input wr_en, wr_ovl, wr_idx, wr_data, host_ovl, host_idx,
        input pix_idx, pix_ovl,
        output host_data, pix_data
    );
endinterface

// ==== rtl/pal_sync.sv ====
`timescale 1ns/1ps
`include "pal_regs.svh"
module pal_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// ==== sim/pal_host_bfm.sv ====
`timescale 1ns/1ps
module pal_host_bfm (
    input wire logic clk_sys_i,
    input wire logic oe_i,
    input wire logic [7:0] bus_i,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [2:0] sel_o,
    output logic [7:0] drv_o
);
    initial begin
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        sel_o = 3'h0;
        drv_o = 8'h00;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Select and data held past the strobe rise
    task automatic wr_cyc(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_sys_i);
        sel_o <= s;
        drv_o <= d;
        wr_n_o <= 1'b0;
        idle(3);
        wr_n_o <= 1'b1;
        idle(4);
        drv_o <= ~d;
        idle(2);
    endtask
    task automatic rd_cyc(input logic [2:0] s, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        sel_o <= s;
        rd_n_o <= 1'b0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (oe_i !== 1'b1 && n < 10);
        d = (oe_i === 1'b1) ? bus_i : 8'hXX;
        @(posedge clk_sys_i);
        rd_n_o <= 1'b1;
        idle(6);
    endtask
endmodule

// ==== sim/pal_host_port_asserts.sv ====
`timescale 1ns/1ps
module pal_chk (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic rd_n_i,
    input wire logic [2:0] reg_select_i,
    input wire logic width_sel_i,
    input wire logic [7:0] host_bus_o,
    input wire logic host_bus_oe_o,
    input wire pal_pkg::pal_color_t color_o,
    input wire pal_pkg::pal_byte_t palette_pointer_o,
    input wire pal_pkg::pal_mode_e access_mode_o
);
    import pal_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_bus_release: assert property (
        rd_n_i [*5] |-> !host_bus_oe_o) else $error("bus driven idle");
    a_bus_zero: assert property (
        !host_bus_oe_o |-> host_bus_o == 8'h00) else $error("bus not zero");
    a_answer_time: assert property (
        $fell(rd_n_i) |-> ##[3:5] host_bus_oe_o) else $error("no answer");
    a_drive_cause: assert property (
        $rose(host_bus_oe_o) |-> $past(!rd_n_i, 3)) else $error("bad drive");
    a_six_bit_top: assert property (
        host_bus_oe_o && !width_sel_i && reg_select_i[1:0] == 2'h1
        |-> host_bus_o[7:6] == 2'h0) else $error("top bits set");
    a_rsvd_zero: assert property (
        host_bus_oe_o && reg_select_i == 3'h6 |-> host_bus_o == 8'h00)
        else $error("reserved read");
    a_ptr_read_keep: assert property (
        !rd_n_i && reg_select_i[1:0] == 2'h3 |=>
        $stable(palette_pointer_o) && $stable(access_mode_o))
        else $error("pointer read altered");
    a_ptr_step_one: assert property (
        $changed(palette_pointer_o) && reg_select_i[1] != reg_select_i[0]
        |-> palette_pointer_o == $past(palette_pointer_o) + 8'h01)
        else $error("pointer step");
    a_color_hold: assert property (
        !rd_n_i [*4] |=> $stable(color_o)) else $error("color moved");
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import pal_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic width_sel_i = 1'b1;
    logic [7:0] pixel_i = 8'h00;
    logic [3:0] overlay_i = 4'h0;
    logic rd_n, wr_n, oe;
    logic [2:0] sel;
    logic [7:0] drv, bus_o;
    wire [7:0] bus_w = oe ? bus_o : drv;
    pal_color_t color_o;
    pal_byte_t ptr_o;
    pal_mode_e mode_o;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 76415;
    int ptr = 0, cnt = 0, mask = 255;
    int ram [256];
    int ovl [16];
    int comp [3];
    pal_host_port i_dut (.clk_sys_i, .reset_n_i, .rd_n_i(rd_n),
        .wr_n_i(wr_n), .reg_select_i(sel), .host_bus_i(bus_w),
        .host_bus_o(bus_o), .host_bus_oe_o(oe), .width_sel_i,
        .pixel_i, .overlay_i, .color_o, .palette_pointer_o(ptr_o),
        .access_mode_o(mode_o));
    pal_host_bfm i_host (.clk_sys_i, .oe_i(oe), .bus_i(bus_w),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel), .drv_o(drv));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    function automatic int comp_of(int e);
        int v;
        v = (e >> (16 - 8 * cnt)) & 255;
        return width_sel_i ? v : v & 63;
    endfunction
    task automatic step;
        if (cnt == 2) begin
            ptr = (ptr + 1) % 256;
            cnt = 0;
        end else
            cnt++;
    endtask
    task automatic hw(input logic [2:0] s, input logic [7:0] d);
        int v, w;
        i_host.wr_cyc(s, d);
        v = width_sel_i ? d : d & 8'h3F;
        if (s[1] == s[0]) begin
            ptr = d;
            cnt = 0;
            chk("mode", mode_o, {s[2], s[0]});
        end else if (s == 3'h2)
            mask = d;
        else if (s != 3'h6) begin
            comp[cnt] = v;
            w = (comp[0] << 16) | (comp[1] << 8) | comp[2];
            if (cnt == 2 && s == 3'h1)
                ram[ptr] = w;
            else if (cnt == 2 && ptr % 16 != 0)
                ovl[ptr % 16] = w;
            step;
        end
        chk("ptr", ptr_o, ptr);
    endtask
    task automatic hr(input logic [2:0] s);
        logic [7:0] d;
        int e;
        e = 0;
        i_host.rd_cyc(s, d);
        if (s[1] == s[0])
            e = ptr;
        else if (s == 3'h2)
            e = mask;
        else if (s != 3'h6) begin
            e = comp_of(s == 3'h1 ? ram[ptr] : ovl[ptr % 16]);
            step;
        end
        chk("read", d, e);
    endtask
    task automatic pix;
        @(posedge clk_sys_i);
        pixel_i <= 8'($random(seed));
        overlay_i <= ($random(seed) % 3 == 0) ? 4'($random(seed)) : 4'h0;
        repeat (3) @(negedge clk_sys_i);
        chk("color", color_o, (overlay_i != 0) ? ovl[overlay_i] :
            ram[pixel_i & mask]);
    endtask
    initial begin
        logic [2:0] s;
        logic [7:0] d;
        repeat (4) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        hr(3'h0);
        hr(3'h2);
        hw(3'h0, 8'hFF);
        repeat (3) hw(3'h1, $random(seed));
        hw(3'h3, 8'hFF);
        hr(3'h1);
        hr(3'h7);
        hr(3'h1);
        hr(3'h1);
        hr(3'h0);
        repeat (500) begin
            @(posedge clk_sys_i);
            width_sel_i <= $random(seed);
            s = $random(seed);
            d = ($random(seed) % 4 == 0) ? 8'hFF : $random(seed);
            if ($random(seed) % 2)
                hw(s, d);
            else
                hr(s);
            pix;
        end
        close_out;
    end
    initial begin
        #(40 * 40000);
        mismatches++;
        close_out;
    end
endmodule
bind pal_host_port pal_chk i_chk (.clk_sys_i, .reset_n_i, .rd_n_i,
    .reg_select_i, .width_sel_i, .host_bus_o, .host_bus_oe_o,
    .color_o, .palette_pointer_o, .access_mode_o);
